/* hw/e1lc_top.sv */
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "e1lc_defines.svh"
// What this block does
// R1: the 2.048 MHz master rate is multiplied by sixteen to make the oversampling rate.
// R2: receive clock and data are recovered by sampling the line sixteen times per bit.
// R3: normally the recovered clock output follows the clock recovered from the line.
// R4: with no marks on the line, carrier loss is flagged and, unless the attenuator is in the receive path, the master clock drives the output.
// R5: with the attenuator in the receive path the recovered clock is near 50% duty.
// R6: build-out codes 000 and 001 select 75 and 120 ohm normal waveforms.
// R7: codes 010 and 011 select the 75 and 120 ohm waveforms for protection resistors.
// R8: codes 100 and 110 select the 75 ohm high return loss waveforms.
// R9: the attenuator depth is 32 or 128 bits by the depth select bit.
// R10: the path select bit puts the attenuator in the receive or transmit path.
// R11: the bypass bit removes the attenuator from its path.
// R12: a smoothed clock made from the 32.768 MHz oversampling rate reads the attenuator fifo.
// R13: the transmit clock input may be gapped or bursty when the attenuator is on that side.
// R14: excess jitter is detected at 120 or 28 UIpp for the deep or shallow fifo.
// R15: on excess jitter the read divider runs at 15 or 17 instead of 16.
// R16: any departure from divide by 16 sets the limit trip flag at bit 5 of the info register.
// R17: a bypassed path passes data straight through on its own clock.
module e1lc_top
   import e1lc_pkg::*;
#(
   parameter int JA_MAX = `E1LC_JA_DEEP
) (
   input  wire logic        clk,                 // 125 MHz
   input  wire logic        reset,               // sync, active high
   input  wire logic [7:0]  avs_address,         // byte address
   input  wire logic        avs_read,            // read request
   input  wire logic        avs_write,           // write request
   input  wire logic [31:0] avs_writedata,       // write data
   input  wire logic [3:0]  avs_byteenable,      // byte lanes
   output logic [31:0]      avs_readdata,        // read data
   output logic             avs_waitrequest,     // stall
   output logic             irq,                 // level interrupt
   input  wire logic        receive_line_pos,    // positive mark
   input  wire logic        receive_line_neg,    // negative mark
   input  wire logic        transmit_clock_in,   // tx bit clock
   input  wire logic        tx_data_in,          // tx nrz data
   output logic             recovered_clock_out, // receive clock
   output e1lc_bit_t        rx_out,              // receive data and strobe
   output e1lc_bit_t        tx_out,              // transmit data and strobe
   output logic             transmit_clock,      // line side tx clock
   output e1lc_lbo_t        tx_waveform,         // waveform to the dac
   output logic             tx_power_down,       // driver off
   output logic             carrier_loss         // loss level
);
   localparam int CLK_KHZ = `E1LC_CLK_KHZ;
   localparam int OVS_KHZ = `E1LC_MCLK_KHZ * `E1LC_PLL_MULT;
   localparam int AW      = $clog2(JA_MAX);

   // refused at elaboration: the fifo pointers and the nco assume these
   if (JA_MAX != `E1LC_JA_DEEP) begin : g_bad_depth
      $error("JA_MAX must be 128");
   end
   if (OVS_KHZ * 2 > CLK_KHZ) begin : g_bad_clock
      $error("clock too slow for oversampling");
   end

   e1lc_line_interface_control_t  line_interface_control_r;
   logic [7:0]  mask_r;
   logic [7:0]  rir_r;
   logic        waitreq_r;
   logic [31:0] rdata_r;
   logic        irq_r;

   // ---------------- pll stand-in: exact fractional rate
   logic [16:0] nco_r;
   logic        samp_en;
   logic [3:0]  mclk_ph_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         nco_r <= 17'h00000;
      end else if (nco_r >= 17'(CLK_KHZ - OVS_KHZ)) begin // [R1]
         nco_r <= nco_r + 17'(OVS_KHZ) - 17'(CLK_KHZ);
      end else begin
         nco_r <= nco_r + 17'(OVS_KHZ);
      end
   end
   assign samp_en = (nco_r >= 17'(CLK_KHZ - OVS_KHZ));

   always_ff @(posedge clk) begin
      if (reset) begin
         mclk_ph_r <= 4'h0;
      end else if (samp_en) begin
         mclk_ph_r <= mclk_ph_r + 4'h1;  // master rate is the oversample rate over 16
      end
   end

   // ---------------- oversampling recovery
   logic       mark_d_r;
   logic [3:0] bit_ph_r;
   logic       seen_r;
   logic [7:0] zeros_r;
   logic       cl_r;
   logic       rec_tick;
   logic       mark;
   assign mark     = receive_line_pos | receive_line_neg;
   assign rec_tick = samp_en && (bit_ph_r == 4'(`E1LC_OVS - 1));

   always_ff @(posedge clk) begin
      if (reset) begin
         mark_d_r <= 1'b0;
         bit_ph_r <= 4'h0;
         seen_r   <= 1'b0;
      end else if (samp_en) begin
         mark_d_r <= mark;
         // rising mark edge realigns the bit phase; every later tick follows from it
         if (mark && !mark_d_r) begin
            bit_ph_r <= 4'h0; // [R2]
         end else begin
            bit_ph_r <= bit_ph_r + 4'h1;
         end
         if (rec_tick) begin
            seen_r <= mark;
         end else if (mark) begin
            seen_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         zeros_r <= 8'h00;
         cl_r    <= 1'b1;
      end else if (rec_tick) begin
         if (seen_r) begin
            zeros_r <= 8'h00;
            cl_r    <= 1'b0;
         end else if (zeros_r == 8'(`E1LC_CL_ZEROS - 1)) begin
            cl_r    <= 1'b1; // [R4]
         end else begin
            zeros_r <= zeros_r + 8'h01;
         end
      end
   end

   // receive source: line bits, or master timing with zero data on loss
   e1lc_bit_t rx_src;
   always_comb begin
      rx_src.en   = cl_r ? (samp_en && mclk_ph_r == 4'hF) : rec_tick; // [R4]
      rx_src.data = cl_r ? 1'b0 : seen_r;
   end

   // ---------------- transmit source
   logic      transmit_clock_d_r;
   e1lc_bit_t tx_src;
   always_ff @(posedge clk) begin
      if (reset) begin
         transmit_clock_d_r <= 1'b0;
      end else begin
         transmit_clock_d_r <= transmit_clock_in;
      end
   end
   // any gap pattern is fine: writes are strobed only on real edges
   assign tx_src.en   = transmit_clock_in && !transmit_clock_d_r; // [R13]
   assign tx_src.data = tx_data_in;

   // ---------------- jitter attenuator
   logic          ja_on;
   logic          ja_tx;
   logic [AW:0]   depth;
   logic [AW:0]   lo_lim;
   logic [AW:0]   hi_lim;
   e1lc_bit_t     ja_in;
   logic          mem [JA_MAX];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0]   fill_r;
   logic          primed_r;
   logic          do_wr;
   logic          do_rd;
   logic          rd_tick;
   logic [4:0]    div_cnt_r;
   logic [4:0]    div_len;
   e1lc_div_t     div_r;
   e1lc_line_interface_control_t    line_interface_control_d_r;
   logic          flush;

   assign ja_on  = !line_interface_control_r.jitter_bypass;                                        // [R11]
   assign ja_tx  = line_interface_control_r.jitter_path_select;                                    // [R10]
   assign depth  = line_interface_control_r.jitter_depth_select ? (AW+1)'(`E1LC_JA_SHALLOW)
                                              : (AW+1)'(`E1LC_JA_DEEP);          // [R9]
   // trip points sit symmetric about the centre, spanning the jitter limit
   assign lo_lim = line_interface_control_r.jitter_depth_select
                   ? (AW+1)'((`E1LC_JA_SHALLOW - `E1LC_JA_THR_SHALLOW) / 2)
                   : (AW+1)'((`E1LC_JA_DEEP - `E1LC_JA_THR_DEEP) / 2);           // [R14]
   assign hi_lim = depth - lo_lim;
   assign ja_in  = ja_tx ? tx_src : rx_src;
   assign flush  = (line_interface_control_d_r.jitter_depth_select != line_interface_control_r.jitter_depth_select)
                   || (line_interface_control_d_r.jitter_path_select != line_interface_control_r.jitter_path_select) || !ja_on;
   assign do_wr  = ja_in.en && (fill_r < depth);
   assign do_rd  = rd_tick && primed_r && (fill_r != '0);
   assign rd_tick = samp_en && (div_cnt_r == div_len - 5'h01);

   always_ff @(posedge clk) begin
      if (reset) begin
         line_interface_control_d_r <= e1lc_line_interface_control_t'(`E1LC_LINE_INTERFACE_CONTROL_RST);
      end else begin
         line_interface_control_d_r <= line_interface_control_r;
      end
   end

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wptr_r] <= ja_in.data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || flush) begin
         wptr_r   <= '0;
         rptr_r   <= '0;
         fill_r   <= '0;
         primed_r <= 1'b0;
      end else begin
         if (do_wr) begin
            wptr_r <= (wptr_r == AW'(depth - 1)) ? '0 : wptr_r + 1'b1;
         end
         if (do_rd) begin
            rptr_r <= (rptr_r == AW'(depth - 1)) ? '0 : rptr_r + 1'b1;
         end
         fill_r <= fill_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
         // reading starts at half full so the fifo is centred
         if (fill_r >= (depth >> 1)) begin
            primed_r <= 1'b1;
         end
      end
   end

   always_comb begin
      unique case (div_r)
         E1LC_DIV15: div_len = 5'(`E1LC_DIV_FAST);
         E1LC_DIV17: div_len = 5'(`E1LC_DIV_SLOW);
         default:    div_len = 5'(`E1LC_DIV_NOM);
      endcase
   end

   // smoothed read clock from the 32.768 MHz rate
   always_ff @(posedge clk) begin
      if (reset) begin
         div_cnt_r <= 5'h00;
         div_r     <= E1LC_DIV16;
      end else if (samp_en) begin
         if (rd_tick) begin
            div_cnt_r <= 5'h00; // [R12]
            if (primed_r && fill_r > hi_lim) begin
               div_r <= E1LC_DIV15; // [R15]
            end else if (primed_r && fill_r < lo_lim) begin
               div_r <= E1LC_DIV17; // [R15]
            end else begin
               div_r <= E1LC_DIV16;
            end
         end else begin
            div_cnt_r <= div_cnt_r + 5'h01;
         end
      end
   end

   // ---------------- path outputs
   logic rd_bit;
   assign rd_bit = mem[rptr_r];
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_out         <= '0;
         tx_out         <= '0;
         transmit_clock <= 1'b0;
      end else begin
         if (ja_on && !ja_tx) begin
            rx_out <= '{data: rd_bit, en: do_rd};
         end else begin
            rx_out <= rx_src; // [R17]
         end
         if (ja_on && ja_tx) begin
            tx_out         <= '{data: rd_bit, en: do_rd};
            transmit_clock <= div_cnt_r < (div_len >> 1);
         end else begin
            tx_out         <= tx_src; // [R17]
            transmit_clock <= transmit_clock_in;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         recovered_clock_out <= 1'b0;
         carrier_loss        <= 1'b1;
      end else begin
         carrier_loss <= cl_r;
         if (ja_on && !ja_tx) begin
            recovered_clock_out <= div_cnt_r < (div_len >> 1); // [R5]
         end else if (cl_r) begin
            recovered_clock_out <= mclk_ph_r < 4'h8; // [R4]
         end else begin
            // short high phase of the raw oversampled clock
            recovered_clock_out <= bit_ph_r < 4'(`E1LC_RCLK_SHORT_HI); // [R3]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_waveform   <= E1LC_LBO_75_NORM;
         tx_power_down <= 1'b0;
      end else begin
         tx_power_down <= line_interface_control_r.tx_power_down;
         unique case (line_interface_control_r.build_out_select)
            3'h0:    tx_waveform <= E1LC_LBO_75_NORM;  // [R6]
            3'h1:    tx_waveform <= E1LC_LBO_120_NORM; // [R6]
            3'h2:    tx_waveform <= E1LC_LBO_75_PROT;  // [R7]
            3'h3:    tx_waveform <= E1LC_LBO_120_PROT; // [R7]
            3'h4:    tx_waveform <= E1LC_LBO_75_HRL15; // [R8]
            3'h6:    tx_waveform <= E1LC_LBO_75_HRL36; // [R8]
            default: tx_waveform <= E1LC_LBO_NONE;
         endcase
      end
   end

   // ---------------- avalon slave, one wait state
   logic wr_go;
   logic cl_ev;
   logic jitter_limit_trip_ev;
   logic cl_d_r;
   assign wr_go   = avs_write && !waitreq_r && avs_byteenable[0];
   assign jitter_limit_trip_ev = rd_tick && (div_r != E1LC_DIV16);
   assign cl_ev   = cl_r && !cl_d_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         waitreq_r <= 1'b1;
         rdata_r   <= 32'h00000000;
      end else begin
         waitreq_r <= !((avs_read || avs_write) && waitreq_r);
         if (avs_read && waitreq_r) begin
            unique case (avs_address)
               `E1LC_ADDR_LINE_INTERFACE_CONTROL: rdata_r <= {24'h000000, line_interface_control_r};
               `E1LC_ADDR_RIR:  rdata_r <= {24'h000000, rir_r};
               `E1LC_ADDR_MASK: rdata_r <= {24'h000000, mask_r};
               default:         rdata_r <= 32'h00000000;
            endcase
         end
      end
   end
   assign avs_waitrequest = waitreq_r;
   assign avs_readdata    = rdata_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         line_interface_control_r <= e1lc_line_interface_control_t'(`E1LC_LINE_INTERFACE_CONTROL_RST);
         mask_r <= `E1LC_MASK_RST;
      end else if (wr_go && avs_address == `E1LC_ADDR_LINE_INTERFACE_CONTROL) begin
         line_interface_control_r <= e1lc_line_interface_control_t'(avs_writedata[7:0]);
      end else if (wr_go && avs_address == `E1LC_ADDR_MASK) begin
         mask_r <= avs_writedata[7:0];
      end
   end

   // status: hardware set wins over a write-one clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         rir_r  <= 8'h00;
         cl_d_r <= 1'b1;
         irq_r  <= 1'b0;
      end else begin
         cl_d_r <= cl_r;
         if (wr_go && avs_address == `E1LC_ADDR_RIR) begin
            rir_r[`E1LC_RIR_CL_EV] <= rir_r[`E1LC_RIR_CL_EV] & ~avs_writedata[`E1LC_RIR_CL_EV];
            rir_r[`E1LC_RIR_JITTER_LIMIT_TRIP]  <= rir_r[`E1LC_RIR_JITTER_LIMIT_TRIP] & ~avs_writedata[`E1LC_RIR_JITTER_LIMIT_TRIP];
         end
         if (cl_ev) begin
            rir_r[`E1LC_RIR_CL_EV] <= 1'b1;
         end
         if (jitter_limit_trip_ev) begin
            rir_r[`E1LC_RIR_JITTER_LIMIT_TRIP] <= 1'b1; // [R16]
         end
         rir_r[`E1LC_RIR_CL_LIVE] <= cl_r;
         irq_r <= |(rir_r & mask_r & 8'h21);
      end
   end
   assign irq = irq_r;

   // ---------------- checks
   property p_ovs_rate;
      @(posedge clk) disable iff (reset) samp_en |=> !samp_en ##1 !samp_en;
   endproperty
   a_ovs_rate: assert property (p_ovs_rate) else $error("oversample enable too fast"); // [R1]

   property p_bit_len;
      @(posedge clk) disable iff (reset)
         (samp_en && bit_ph_r == 4'h0 && !(mark && !mark_d_r)) |=> (bit_ph_r == 4'h1);
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("bit phase did not advance"); // [R2]

   property p_loss_clock;
      @(posedge clk) disable iff (reset)
         (cl_r && !(ja_on && !ja_tx)) |=> recovered_clock_out == ($past(mclk_ph_r) < 4'h8);
   endproperty
   a_loss_clock: assert property (p_loss_clock) else $error("loss clock not master"); // [R4]

   property p_lbo_hrl;
      @(posedge clk) disable iff (reset)
         line_interface_control_r.build_out_select == 3'h6 |=> tx_waveform == E1LC_LBO_75_HRL36;
   endproperty
   a_lbo_hrl: assert property (p_lbo_hrl) else $error("wrong build-out"); // [R8]

   property p_no_overflow;
      // a depth change leaves the old fill for the one flush cycle
      @(posedge clk) disable iff (reset) !flush |-> fill_r <= depth;
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("fifo past depth"); // [R9]

   property p_bypass_rx;
      @(posedge clk) disable iff (reset)
         (!ja_on || ja_tx) |=> rx_out == $past(rx_src);
   endproperty
   a_bypass_rx: assert property (p_bypass_rx) else $error("bypass not direct"); // [R17]

   property p_jitter_limit_trip;
      @(posedge clk) disable iff (reset) jitter_limit_trip_ev |=> rir_r[`E1LC_RIR_JITTER_LIMIT_TRIP];
   endproperty
   a_jitter_limit_trip: assert property (p_jitter_limit_trip) else $error("limit trip not flagged"); // [R16]

   property p_div_fast;
      @(posedge clk) disable iff (reset)
         (samp_en && rd_tick && primed_r && fill_r > hi_lim && !flush) |=> div_r == E1LC_DIV15;
   endproperty
   a_div_fast: assert property (p_div_fast) else $error("divider not shortened"); // [R15]

   property p_wait;
      @(posedge clk) disable iff (reset)
         ((avs_read || avs_write) && waitreq_r) |=> !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("no bus answer");

   c_loss:   cover property (@(posedge clk) disable iff (reset) cl_ev);
   c_jitter_limit_trip:   cover property (@(posedge clk) disable iff (reset) jitter_limit_trip_ev);
   c_tx_ja:  cover property (@(posedge clk) disable iff (reset) ja_on && ja_tx && do_rd);
   c_irq:    cover property (@(posedge clk) disable iff (reset) irq_r);
endmodule

/* common/e1lc_defines.svh */
`ifndef E1LC_DEFINES_SVH
`define E1LC_DEFINES_SVH
`define E1LC_CLK_KHZ        125000
`define E1LC_MCLK_KHZ       2048
`define E1LC_PLL_MULT       16
`define E1LC_OVS            16
`define E1LC_ADDR_RIR       8'h08
`define E1LC_ADDR_LINE_INTERFACE_CONTROL      8'h18
`define E1LC_ADDR_MASK      8'h1C
`define E1LC_LINE_INTERFACE_CONTROL_RST       8'h00
`define E1LC_MASK_RST       8'h00
`define E1LC_RIR_CL_EV      0
`define E1LC_RIR_JITTER_LIMIT_TRIP       5
`define E1LC_RIR_CL_LIVE    6
`define E1LC_CL_ZEROS       255
`define E1LC_JA_DEEP        128
`define E1LC_JA_SHALLOW     32
`define E1LC_JA_THR_DEEP    120
`define E1LC_JA_THR_SHALLOW 28
`define E1LC_DIV_NOM        16
`define E1LC_DIV_FAST       15
`define E1LC_DIV_SLOW       17
`define E1LC_RCLK_SHORT_HI  6
`endif

/* common/e1lc_pkg.sv */
package e1lc_pkg;
   // control register layout, msb first
   typedef struct packed {
      logic [2:0] build_out_select;
      logic       eq_gain_limit;
      logic       jitter_path_select;  // 0 receive path, 1 transmit path
      logic       jitter_depth_select; // 0 deep, 1 shallow
      logic       jitter_bypass;
      logic       tx_power_down;
   } e1lc_line_interface_control_t;

   typedef enum logic [2:0] {
      E1LC_LBO_75_NORM  = 3'h0,
      E1LC_LBO_120_NORM = 3'h1,
      E1LC_LBO_75_PROT  = 3'h2,
      E1LC_LBO_120_PROT = 3'h3,
      E1LC_LBO_75_HRL15 = 3'h4,
      E1LC_LBO_75_HRL36 = 3'h6,
      E1LC_LBO_NONE     = 3'h7
   } e1lc_lbo_t;

   typedef enum logic [1:0] {
      E1LC_DIV16 = 2'h0,
      E1LC_DIV15 = 2'h1,
      E1LC_DIV17 = 2'h3
   } e1lc_div_t;

   typedef struct packed {
      logic data;
      logic en;
   } e1lc_bit_t;
endpackage

/* testbench/e1lc_line_model.sv */
`timescale 1ns/100ps
module e1lc_line_model (
   input  wire logic       clk,               // 125 MHz
   input  wire logic       reset,             // sync, active high
   input  wire logic       mark_on,           // line carries marks
   input  wire logic       tx_on,             // tx clock runs
   input  wire logic [7:0] tx_half,           // tx half period in cycles
   output logic            receive_line_pos,  // positive mark
   output logic            receive_line_neg,  // negative mark
   output logic            transmit_clock_in, // tx bit clock
   output logic            tx_data_in         // tx data
);
   // 61 cycles a bit is within the oversampler's pull range
   logic [7:0] rx_cnt_r;
   logic [7:0] tx_cnt_r;
   logic       pol_r;
   logic [2:0] pat_r;
   always_ff @(posedge clk) begin
      if (reset || !mark_on) begin
         rx_cnt_r         <= 8'h00;
         receive_line_pos <= 1'b0;
         receive_line_neg <= 1'b0;
      end else begin
         rx_cnt_r         <= (rx_cnt_r == 8'h3C) ? 8'h00 : rx_cnt_r + 8'h01;
         receive_line_pos <= (rx_cnt_r < 8'h1E) && pol_r;
         receive_line_neg <= (rx_cnt_r < 8'h1E) && !pol_r;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         pol_r <= 1'b0;
      end else if (rx_cnt_r == 8'h3C) begin
         pol_r <= !pol_r; // ami: marks alternate
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_cnt_r          <= 8'h00;
         transmit_clock_in <= 1'b0;
         pat_r             <= 3'h0;
         tx_data_in        <= 1'b0;
      end else if (!tx_on && !transmit_clock_in) begin
         tx_cnt_r   <= 8'h00;
         tx_data_in <= !tx_data_in; // gapped clock, data not held
      end else if (tx_cnt_r + 8'h01 >= tx_half) begin
         tx_cnt_r          <= 8'h00;
         transmit_clock_in <= !transmit_clock_in;
         if (transmit_clock_in) begin
            pat_r      <= pat_r + 3'h1;
            tx_data_in <= pat_r[0] ^ pat_r[2];
         end
      end else begin
         tx_cnt_r <= tx_cnt_r + 8'h01;
      end
   end
endmodule

/* testbench/e1lc_top_test.sv */
`timescale 1ns/100ps
module e1lc_top_test;
   import e1lc_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata, rd;
   logic        avs_waitrequest, irq, receive_line_pos, receive_line_neg;
   logic        transmit_clock_in, tx_data_in, recovered_clock_out;
   logic        transmit_clock, tx_power_down, carrier_loss;
   e1lc_bit_t   rx_out, tx_out;
   e1lc_lbo_t   tx_waveform;
   logic        mark_on = 1'b0;
   logic        tx_on = 1'b0;
   logic [7:0]  tx_half = 8'h1E;
   logic        tx_prev, tc_prev, rc_prev;
   logic        q[$];
   bit          tx_cmp = 0;
   int          err_total = 0;
   int          check_count = 0;
   int          rise_n, tc_rise, txen_n, rxen_n, rx_bad, rc_rise, rc_hi;

   always #4 clk = ~clk;

   e1lc_top i_e1lc_top (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .receive_line_pos,
      .receive_line_neg, .transmit_clock_in, .tx_data_in, .recovered_clock_out, .rx_out,
      .tx_out, .transmit_clock, .tx_waveform, .tx_power_down, .carrier_loss);
   e1lc_line_model i_e1lc_line_model (.clk, .reset, .mark_on, .tx_on, .tx_half,
      .receive_line_pos, .receive_line_neg, .transmit_clock_in, .tx_data_in);

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: %s got %0h want %0h", $time, what, got, exp);
      end
   endtask
   task automatic run(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      chk(n < 50, 1, "bus answer");
   endtask
   task automatic meas(input int n);
      {rise_n, tc_rise, txen_n, rxen_n, rx_bad, rc_rise, rc_hi} = '0;
      q.delete();
      run(n);
   endtask
   task automatic wait_loss(input logic lvl, input int lim);
      for (int n = 0; n < lim && carrier_loss !== lvl; n++)
         @(posedge clk);
      chk(carrier_loss, lvl, "carrier state");
   endtask

   always @(posedge clk) begin
      if (transmit_clock_in === 1'b1 && tx_prev === 1'b0) begin
         rise_n++;
         q.push_back(tx_data_in);
      end
      if (transmit_clock === 1'b1 && tc_prev === 1'b0) tc_rise++;
      if (recovered_clock_out === 1'b1 && rc_prev === 1'b0) rc_rise++;
      if (recovered_clock_out === 1'b1) rc_hi++;
      tx_prev = transmit_clock_in;
      tc_prev = transmit_clock;
      rc_prev = recovered_clock_out;
      if (rx_out.en === 1'b1) begin
         rxen_n++;
         if (rx_out.data !== 1'b1) rx_bad++;
      end
      if (tx_out.en === 1'b1) begin
         txen_n++;
         if (tx_cmp) chk(tx_out.data, q.size() ? q.pop_front() : 1'bx, "tx order");
      end
   end

   task automatic t_reset();
      chk(carrier_loss, 1'b1, "loss at reset");
      chk(tx_waveform, E1LC_LBO_75_NORM, "lbo reset");
      bus(1'b0, 8'h18, 8'h00);
      chk(rd, 32'h0, "control reset");
      bus(1'b0, 8'h08, 8'h00);
      chk(rd[6], 1'b1, "live loss");
      bus(1'b1, 8'h04, 8'hFF);
      bus(1'b0, 8'h04, 8'h00);
      chk(rd, 32'h0, "unmapped");
   endtask
   task automatic t_lbo();
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 8'h18, {3'(c), 4'h0, c[0]});
         run(2);
         chk(tx_waveform, (c == 5 || c == 7) ? 3'h7 : 3'(c), "lbo");
         chk(tx_power_down, c[0], "power down");
      end
   endtask
   task automatic t_rx();
      bus(1'b1, 8'h18, 8'h00);
      mark_on <= 1'b1;
      wait_loss(1'b0, 2000);
      run(6000);
      meas(1220);
      chk(rxen_n inside {[18:22]}, 1, "rx rate");
      chk(rx_bad, 0, "rx data");
      chk(rc_rise inside {[19:21]}, 1, "rclk rate");
      chk(rc_hi inside {[490:730]}, 1, "rclk duty");
      bus(1'b1, 8'h18, 8'h02);
      run(200);
      meas(1220);
      chk(rxen_n inside {[18:22]}, 1, "rx bypass");
      chk(rx_bad, 0, "rx bypass data");
      chk(rc_rise inside {[19:21]}, 1, "rclk bypass");
   endtask
   task automatic t_loss();
      bus(1'b1, 8'h08, 8'h21);
      bus(1'b1, 8'h1C, 8'h01);
      mark_on <= 1'b0;
      run(15000);
      chk(carrier_loss, 1'b0, "loss early");
      wait_loss(1'b1, 2500);
      run(3);
      chk(irq, 1'b1, "loss irq");
      bus(1'b0, 8'h08, 8'h00);
      chk(rd & 32'h41, 32'h41, "loss status");
      meas(1220);
      chk(rc_rise inside {[19:21]}, 1, "rclk master");
      bus(1'b1, 8'h1C, 8'h00);
      run(2);
      chk(irq, 1'b0, "masked irq");
      bus(1'b1, 8'h1C, 8'h01);
      bus(1'b1, 8'h08, 8'h01);
      run(2);
      chk(irq, 1'b0, "cleared irq");
      bus(1'b0, 8'h08, 8'h00);
      chk(rd, 32'h40, "event cleared");
   endtask
   task automatic tx_bits(input logic [7:0] ctl, input int n);
      tx_on <= 1'b0;
      run(70);
      // reads still land on the flush edge; not compared, queue restarts
      tx_cmp = 0;
      bus(1'b1, 8'h18, ctl);
      meas(3);
      tx_cmp = 1;
      tx_on <= 1'b1;
      run(n * 60);
   endtask
   task automatic t_tx();
      tx_cmp = 1;
      tx_bits(8'h0A, 20);
      tx_on <= 1'b0;
      run(70);
      chk(txen_n, rise_n, "tx bypass");
      chk(tc_rise, rise_n, "tx clock");
      tx_bits(8'h08, 40);
      chk(txen_n, 0, "deep priming");
      run(3600);
      chk(txen_n > 0, 1, "deep output");
      tx_bits(8'h0C, 30);
      chk(txen_n > 0, 1, "shallow output");
   endtask
   task automatic t_trip();
      tx_cmp = 0;
      tx_on <= 1'b0;
      run(70);
      bus(1'b1, 8'h1C, 8'h20);
      bus(1'b1, 8'h08, 8'h21);
      tx_half <= 8'h04;
      tx_on   <= 1'b1;
      run(480);
      tx_half <= 8'h1E;
      run(2440);
      chk(irq, 1'b1, "trip irq");
      bus(1'b0, 8'h08, 8'h00);
      chk(rd[5], 1'b1, "trip flag");
   endtask

   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      $display("ERROR %0t: watchdog", $time);
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_lbo();
      t_rx();
      t_loss();
      t_tx();
      t_trip();
      print_verdict();
   end
endmodule
